// ===== dsc_pkg.sv
// Contract
// - in speed control the speed reference comes from none (0), the analog input (1) or the setpoint parameter (2).
// - a lost mains phase raises the fault class held in the phase-loss response, coded 1 to 3.
// - an excessive following error raises the class in the following-error response, coded 1 to 3, default 3.
// - ground-fault monitoring runs when its enable is 1 (default) and is suppressed at 0.
// - mains phase monitoring is active when its enable is 1 (default) and inactive at 0.
// - the following error is the position-loop deviation minus the speed-dependent deviation.
// - the following-error limit is a 32-bit value in 0.0001 rev, accepting 1 to 2000000, default 10000.
// - soft limit select: 0 none (default), 1 positive, 2 negative, 3 both directions.
// - soft position limits are checked only while the homing-done flag is 1.
// - the setpoint parameter is a signed speed of -30000 to 30000 rpm, further limited by the maximum speed.
package dsc_pkg;
  // ****************************************
  // parameter addresses
  // ****************************************
  localparam logic [15:0] DSC_ADR_PHASE = 16'h0514;
  localparam logic [15:0] DSC_ADR_FOLLOW = 16'h0516;
  localparam logic [15:0] DSC_ADR_LINE = 16'h051E;
  localparam logic [15:0] DSC_ADR_GROUND = 16'h0520;
  localparam logic [15:0] DSC_ADR_SOFTLIM = 16'h0606;
  localparam logic [15:0] DSC_ADR_FELIM = 16'h121C;
  localparam logic [15:0] DSC_ADR_SPDSRC = 16'h1B22;
  localparam logic [15:0] DSC_ADR_SPDSET = 16'h2108;
  // ****************************************
  // reset values and ranges
  // ****************************************
  localparam logic [15:0] DSC_RST_PHASE = 16'h0002;
  localparam logic [15:0] DSC_RST_FOLLOW = 16'h0003;
  localparam logic [15:0] DSC_RST_LINE = 16'h0001;
  localparam logic [15:0] DSC_RST_GROUND = 16'h0001;
  localparam logic [15:0] DSC_RST_SOFTLIM = 16'h0000;
  localparam logic [31:0] DSC_RST_FELIM = 32'h00002710;
  localparam logic [15:0] DSC_RST_SPDSRC = 16'h0000;
  localparam logic [15:0] DSC_RST_SPDSET = 16'h0000;
  localparam logic signed [32:0] DSC_CLS_MIN = 33'sh000000001;
  localparam logic signed [32:0] DSC_CLS_MAX = 33'sh000000003;
  localparam logic signed [32:0] DSC_BIT_MIN = 33'sh000000000;
  localparam logic signed [32:0] DSC_BIT_MAX = 33'sh000000001;
  localparam logic signed [32:0] DSC_SEL_MAX = 33'sh000000003;
  localparam logic signed [32:0] DSC_SRC_MAX = 33'sh000000002;
  localparam logic signed [32:0] DSC_FELIM_MIN = 33'sh000000001;
  localparam logic signed [32:0] DSC_FELIM_MAX = 33'sh0001E8480;
  localparam logic signed [32:0] DSC_SPD_MIN = -33'sh000007530;
  localparam logic signed [32:0] DSC_SPD_MAX = 33'sh000007530;
  // soft limit select bit positions
  localparam int DSC_SL_POS_BIT = 0;
  localparam int DSC_SL_NEG_BIT = 1;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0]
  {
    DSC_SRC_NONE = 2'b00,
    DSC_SRC_ANALOG = 2'b01,
    DSC_SRC_PARAM = 2'b10
  } dsc_speed_src_e;
  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dsc_req_s;
  typedef struct packed
  {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } dsc_rsp_s;
  typedef struct packed
  {
    logic phase_loss;
    logic follow_err;
    logic ground;
    logic [1:0] cls;
  } dsc_fault_s;
endpackage

// ===== dsc_param_reg.sv
`timescale 1ns/1ps
module dsc_param_reg
  import dsc_pkg::*;
#(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0,
  parameter logic signed [32:0] MINV = 33'sh000000000,
  parameter logic signed [32:0] MAXV = 33'sh000000001,
  parameter bit SGN = 1'b0
)
(
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic wr_i, // write strobe for this parameter
  input wire logic [31:0] wdata_i, // write data
  output logic ok_o, // write data lies in range
  output logic [W-1:0] value_o // stored value
);
  wire logic fill = SGN ? wdata_i[W-1] : 1'b0;
  wire logic signed [32:0] ext = {{(33-W){fill}}, wdata_i[W-1:0]};
  // out-of-range writes are refused and the old value kept
  assign ok_o = (ext >= MINV) && (ext <= MAXV);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      value_o <= RST;
    else if (wr_i && ok_o)
      value_o <= wdata_i[W-1:0];
  end
endmodule

// ===== dsc_top.sv
`timescale 1ns/1ps
module dsc_top
  import dsc_pkg::*;
(
  input wire logic clk_i, // 20 MHz clock
  input wire logic reset_n_i, // async reset, active low
  input wire dsc_req_s param_req_i, // parameter access request
  output dsc_rsp_s param_rsp_o, // parameter access answer
  input wire logic speed_mode_i, // speed control mode active
  input wire logic signed [15:0] analog_input_one_i, // analog ref, rpm
  input wire logic [15:0] max_speed_i, // configured max speed, rpm
  input wire logic phase_loss_i, // one mains phase missing
  input wire logic ground_fault_i, // ground fault detected
  input wire logic signed [31:0] pos_deviation_i, // position deviation
  input wire logic signed [31:0] speed_deviation_i, // speed part
  input wire logic homing_done_i, // homing completed
  input wire logic signed [31:0] pos_actual_i, // actual position
  input wire logic signed [31:0] soft_limit_positive_i, // pos limit
  input wire logic signed [31:0] soft_limit_negative_i, // neg limit
  output logic signed [15:0] speed_ref_o, // speed reference, rpm
  output logic signed [32:0] following_error_o, // following error
  output dsc_fault_s fault_o, // raised faults and class
  output logic limit_pos_hit_o, // positive soft limit passed
  output logic limit_neg_hit_o // negative soft limit passed
);
  // ****************************************
  // parameter decode
  // ****************************************
  wire logic hit_phase = param_req_i.addr == DSC_ADR_PHASE;
  wire logic hit_follow = param_req_i.addr == DSC_ADR_FOLLOW;
  wire logic hit_line = param_req_i.addr == DSC_ADR_LINE;
  wire logic hit_ground = param_req_i.addr == DSC_ADR_GROUND;
  wire logic hit_softlim = param_req_i.addr == DSC_ADR_SOFTLIM;
  wire logic hit_felim = param_req_i.addr == DSC_ADR_FELIM;
  wire logic hit_spdsrc = param_req_i.addr == DSC_ADR_SPDSRC;
  wire logic hit_spdset = param_req_i.addr == DSC_ADR_SPDSET;
  wire logic hit_any = hit_phase | hit_follow | hit_line | hit_ground |
    hit_softlim | hit_felim | hit_spdsrc | hit_spdset;
  wire logic wr = param_req_i.wr;
  logic ok_phase;
  logic ok_follow;
  logic ok_line;
  logic ok_ground;
  logic ok_softlim;
  logic ok_felim;
  logic ok_spdsrc;
  logic ok_spdset;
  logic [15:0] phase_loss_response;
  logic [15:0] following_error_response;
  logic [15:0] line_phase_monitor_enable;
  logic [15:0] ground_fault_monitor_enable;
  logic [15:0] soft_limit_select;
  logic [31:0] following_error_limit;
  logic [15:0] speed_source_select;
  logic [15:0] speed_setpoint;
  // ****************************************
  // parameter storage
  // ****************************************
  dsc_param_reg #(.W(16), .RST(DSC_RST_PHASE), .MINV(DSC_CLS_MIN),
    .MAXV(DSC_CLS_MAX), .SGN(1'b0)) u_phase
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_phase),
    .wdata_i(param_req_i.wdata), .ok_o(ok_phase),
    .value_o(phase_loss_response)
  );
  dsc_param_reg #(.W(16), .RST(DSC_RST_FOLLOW), .MINV(DSC_CLS_MIN),
    .MAXV(DSC_CLS_MAX), .SGN(1'b0)) u_follow
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_follow),
    .wdata_i(param_req_i.wdata), .ok_o(ok_follow),
    .value_o(following_error_response)
  );
  dsc_param_reg #(.W(16), .RST(DSC_RST_LINE), .MINV(DSC_BIT_MIN),
    .MAXV(DSC_BIT_MAX), .SGN(1'b0)) u_line
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_line),
    .wdata_i(param_req_i.wdata), .ok_o(ok_line),
    .value_o(line_phase_monitor_enable)
  );
  dsc_param_reg #(.W(16), .RST(DSC_RST_GROUND), .MINV(DSC_BIT_MIN),
    .MAXV(DSC_BIT_MAX), .SGN(1'b0)) u_ground
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_ground),
    .wdata_i(param_req_i.wdata), .ok_o(ok_ground),
    .value_o(ground_fault_monitor_enable)
  );
  dsc_param_reg #(.W(16), .RST(DSC_RST_SOFTLIM), .MINV(DSC_BIT_MIN),
    .MAXV(DSC_SEL_MAX), .SGN(1'b0)) u_softlim
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_softlim),
    .wdata_i(param_req_i.wdata), .ok_o(ok_softlim),
    .value_o(soft_limit_select)
  );
  dsc_param_reg #(.W(32), .RST(DSC_RST_FELIM), .MINV(DSC_FELIM_MIN),
    .MAXV(DSC_FELIM_MAX), .SGN(1'b0)) u_felim
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_felim),
    .wdata_i(param_req_i.wdata), .ok_o(ok_felim),
    .value_o(following_error_limit)
  );
  dsc_param_reg #(.W(16), .RST(DSC_RST_SPDSRC), .MINV(DSC_BIT_MIN),
    .MAXV(DSC_SRC_MAX), .SGN(1'b0)) u_spdsrc
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_spdsrc),
    .wdata_i(param_req_i.wdata), .ok_o(ok_spdsrc),
    .value_o(speed_source_select)
  );
  dsc_param_reg #(.W(16), .RST(DSC_RST_SPDSET), .MINV(DSC_SPD_MIN),
    .MAXV(DSC_SPD_MAX), .SGN(1'b1)) u_spdset
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr && hit_spdset),
    .wdata_i(param_req_i.wdata), .ok_o(ok_spdset),
    .value_o(speed_setpoint)
  );
  // ****************************************
  // access answer
  // ****************************************
  wire logic ok_sel = (hit_phase & ok_phase) | (hit_follow & ok_follow) |
    (hit_line & ok_line) | (hit_ground & ok_ground) |
    (hit_softlim & ok_softlim) | (hit_felim & ok_felim) |
    (hit_spdsrc & ok_spdsrc) | (hit_spdset & ok_spdset);
  wire logic [31:0] rd_mux =
    hit_phase ? {16'h0000, phase_loss_response} :
    hit_follow ? {16'h0000, following_error_response} :
    hit_line ? {16'h0000, line_phase_monitor_enable} :
    hit_ground ? {16'h0000, ground_fault_monitor_enable} :
    hit_softlim ? {16'h0000, soft_limit_select} :
    hit_felim ? following_error_limit :
    hit_spdsrc ? {16'h0000, speed_source_select} :
    hit_spdset ? {{16{speed_setpoint[15]}}, speed_setpoint} : 32'h00000000;
  wire logic req_any = param_req_i.rd | param_req_i.wr;
  wire logic req_err = !hit_any || (param_req_i.wr && !ok_sel);
  dsc_rsp_s rsp_next;
  assign rsp_next.ack = req_any;
  assign rsp_next.err = req_any && req_err;
  assign rsp_next.rdata = (param_req_i.rd && hit_any) ? rd_mux : 32'h00000000;
  // ****************************************
  // speed reference
  // ****************************************
  wire dsc_speed_src_e src = dsc_speed_src_e'(speed_source_select[1:0]);
  wire logic signed [16:0] max_pos = {1'b0, max_speed_i};
  wire logic signed [16:0] max_neg = -max_pos;
  wire logic signed [16:0] set_ext = {speed_setpoint[15], speed_setpoint};
  wire logic signed [16:0] set_lim = (set_ext > max_pos) ? max_pos :
    (set_ext < max_neg) ? max_neg : set_ext;
  logic signed [15:0] speed_ref_next;
  always_comb
  begin
    speed_ref_next = 16'sh0000;
    if (speed_mode_i)
    begin
      unique case (src)
        DSC_SRC_NONE: speed_ref_next = 16'sh0000;
        DSC_SRC_ANALOG: speed_ref_next = analog_input_one_i;
        DSC_SRC_PARAM: speed_ref_next = set_lim[15:0];
        default: speed_ref_next = 16'sh0000;
      endcase
    end
  end
  // ****************************************
  // supervision
  // ****************************************
  wire logic signed [32:0] fe_diff = {pos_deviation_i[31], pos_deviation_i} -
    {speed_deviation_i[31], speed_deviation_i};
  wire logic [32:0] fe_mag = fe_diff[32] ? 33'(-fe_diff) : 33'(fe_diff);
  wire logic fe_over = fe_mag > {1'b0, following_error_limit};
  wire logic ph_evt = line_phase_monitor_enable[0] &&
    phase_loss_i;
  wire logic gnd_evt = ground_fault_monitor_enable[0] &&
    ground_fault_i;
  wire logic [1:0] ph_cls = ph_evt ? phase_loss_response[1:0] :
    2'h0;
  wire logic [1:0] fe_cls = fe_over ? following_error_response[1:0] :
    2'h0;
  dsc_fault_s fault_next;
  assign fault_next.phase_loss = ph_evt;
  assign fault_next.follow_err = fe_over;
  assign fault_next.ground = gnd_evt;
  assign fault_next.cls = (ph_cls > fe_cls) ? ph_cls : fe_cls;
  wire logic lim_on = homing_done_i;
  wire logic pos_next = lim_on && soft_limit_select[DSC_SL_POS_BIT] &&
    (pos_actual_i > soft_limit_positive_i);
  wire logic neg_next = lim_on && soft_limit_select[DSC_SL_NEG_BIT] &&
    (pos_actual_i < soft_limit_negative_i);
  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      param_rsp_o <= '0;
      speed_ref_o <= 16'sh0000;
      following_error_o <= 33'sh000000000;
      fault_o <= '0;
      limit_pos_hit_o <= 1'b0;
      limit_neg_hit_o <= 1'b0;
    end
    else
    begin
      param_rsp_o <= rsp_next;
      speed_ref_o <= speed_ref_next;
      following_error_o <= fe_diff;
      fault_o <= fault_next;
      limit_pos_hit_o <= pos_next;
      limit_neg_hit_o <= neg_next;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_src_param;
    speed_mode_i && src == DSC_SRC_PARAM |=>
      speed_ref_o == $past(set_lim[15:0]);
  endproperty
  a_src_param: assert property (p_src_param)
    else $error("speed ref not from setpoint");
  property p_src_none;
    !speed_mode_i || src == DSC_SRC_NONE |=> speed_ref_o == 16'sh0000;
  endproperty
  a_src_none: assert property (p_src_none)
    else $error("speed ref not zero");
  property p_phase_cls;
    ph_evt && !fe_over |=> fault_o.phase_loss &&
      fault_o.cls == $past(phase_loss_response[1:0]);
  endproperty
  a_phase_cls: assert property (p_phase_cls)
    else $error("phase loss class wrong");
  property p_follow_cls;
    fe_over && !ph_evt |=> fault_o.follow_err &&
      fault_o.cls == $past(following_error_response[1:0]);
  endproperty
  a_follow_cls: assert property (p_follow_cls)
    else $error("following error class wrong");
  property p_ground_off;
    ground_fault_monitor_enable == 16'h0000 |=> !fault_o.ground;
  endproperty
  a_ground_off: assert property (p_ground_off)
    else $error("ground fault not suppressed");
  property p_line_off;
    line_phase_monitor_enable == 16'h0000 |=> !fault_o.phase_loss;
  endproperty
  a_line_off: assert property (p_line_off)
    else $error("phase monitor not suppressed");
  property p_fe_value;
    1'b1 |=> following_error_o ==
      $past(pos_deviation_i) - $past(speed_deviation_i);
  endproperty
  a_fe_value: assert property (p_fe_value)
    else $error("following error value wrong");
  property p_felim_range;
    wr && hit_felim && param_req_i.wdata == 32'h00000000 |=>
      following_error_limit == $past(following_error_limit) && param_rsp_o.err;
  endproperty
  a_felim_range: assert property (p_felim_range)
    else $error("zero limit accepted");
  property p_homing;
    !homing_done_i |=> !limit_pos_hit_o && !limit_neg_hit_o;
  endproperty
  a_homing: assert property (p_homing)
    else $error("soft limit checked before homing");
  property p_sel_pos;
    soft_limit_select[DSC_SL_POS_BIT] == 1'b0 |=> !limit_pos_hit_o;
  endproperty
  a_sel_pos: assert property (p_sel_pos)
    else $error("positive limit not selected");
  property p_fe_edge;
    $rose(fe_over) |=> fault_o.follow_err &&
      fault_o.cls >= $past(following_error_response[1:0]);
  endproperty
  a_fe_edge: assert property (p_fe_edge)
    else $error("following error not raised");
  property p_spd_clamp;
    speed_mode_i && src == DSC_SRC_PARAM |=>
      speed_ref_o <= $past(max_pos) && speed_ref_o >= $past(max_neg);
  endproperty
  a_spd_clamp: assert property (p_spd_clamp)
    else $error("setpoint not limited");
  property p_src_analog;
    speed_mode_i && src == DSC_SRC_ANALOG |=>
      speed_ref_o == $past(analog_input_one_i);
  endproperty
  a_src_analog: assert property (p_src_analog)
    else $error("speed ref not from analog input");
  property p_phase_on;
    line_phase_monitor_enable[0] && phase_loss_i |=> fault_o.phase_loss;
  endproperty
  a_phase_on: assert property (p_phase_on)
    else $error("phase loss not reported");
  property p_ground_on;
    ground_fault_monitor_enable[0] && ground_fault_i |=> fault_o.ground;
  endproperty
  a_ground_on: assert property (p_ground_on)
    else $error("ground fault not reported");
  property p_sel_neg;
    soft_limit_select[DSC_SL_NEG_BIT] == 1'b0 |=> !limit_neg_hit_o;
  endproperty
  a_sel_neg: assert property (p_sel_neg)
    else $error("negative limit not selected");
  property p_fe_quiet;
    !fe_over |=> !fault_o.follow_err;
  endproperty
  a_fe_quiet: assert property (p_fe_quiet)
    else $error("following error raised within limit");
  property p_cls_none;
    !ph_evt && !fe_over |=> fault_o.cls == 2'h0;
  endproperty
  a_cls_none: assert property (p_cls_none)
    else $error("fault class without fault");
  c_follow: cover property (fe_over ##1 fault_o.follow_err);
  c_phase: cover property (ph_evt ##1 fault_o.phase_loss);
  c_write: cover property (wr && hit_spdsrc && ok_spdsrc);
  c_limit: cover property (homing_done_i ##1 limit_pos_hit_o);
endmodule

// ===== dsc_master_model.sv
`timescale 1ns/1ps
module dsc_master_model
  import dsc_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire dsc_rsp_s rsp_i, // answer from the device
  output dsc_req_s req_o // request to the device
);
  // ****************************************
  // fieldbus master access
  // ****************************************
  initial req_o = '0;
  // one-cycle request, then fields scrambled so stale values never match
  task automatic access(input logic wr, input logic [15:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    int n;
    @(negedge clk_i);
    req_o = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(negedge clk_i);
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    n = 0;
    while (rsp_i.ack !== 1'b1 && n < 4)
    begin
      @(negedge clk_i);
      n++;
    end
    rdata = rsp_i.rdata;
    err = (rsp_i.ack === 1'b1) ? rsp_i.err : 1'bx;
  endtask
endmodule

// ===== tb_drive_supervision_config.sv
`timescale 1ns/1ps
module tb_drive_supervision_config;
  import dsc_pkg::*;
  // ****************************************
  // signals and helpers
  // ****************************************
  logic clk_i, reset_n_i, speed_mode_i, phase_loss_i, ground_fault_i;
  logic homing_done_i, limit_pos_hit_o, limit_neg_hit_o, ph, fe, gr;
  logic signed [15:0] analog_input_one_i, speed_ref_o;
  logic [15:0] max_speed_i;
  logic signed [31:0] pos_deviation_i, speed_deviation_i, pos_actual_i;
  logic signed [31:0] soft_limit_positive_i, soft_limit_negative_i;
  logic signed [32:0] following_error_o;
  dsc_req_s param_req_i;
  dsc_rsp_s param_rsp_o;
  dsc_fault_s fault_o, exp_f;
  int n_mismatch = 0;
  int check_count = 0;
  int sp, dv, lim;
  logic [31:0] seed = 32'hCFC3;
  logic [1:0] src, pc, fc;
  logic [15:0] adr_t [8] = '{DSC_ADR_PHASE, DSC_ADR_FOLLOW, DSC_ADR_LINE,
    DSC_ADR_GROUND, DSC_ADR_SOFTLIM, DSC_ADR_FELIM, DSC_ADR_SPDSRC,
    DSC_ADR_SPDSET};
  logic [31:0] rst_t [8] = '{32'h2, 32'h3, 32'h1, 32'h1, 32'h0, 32'h2710,
    32'h0, 32'h0};
  // out-of-range writes: register index and data
  int bad_i [10] = '{0, 0, 1, 2, 3, 4, 5, 5, 6, 7};
  logic [31:0] bad_d [10] = '{32'h0, 32'h4, 32'h0, 32'h2, 32'h2, 32'h4,
    32'h0, 32'h1E8481, 32'h3, 32'h7531};

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  dsc_master_model u_mst (.clk_i(clk_i), .rsp_i(param_rsp_o),
    .req_o(param_req_i));

  dsc_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .param_req_i(param_req_i), .param_rsp_o(param_rsp_o),
    .speed_mode_i(speed_mode_i), .analog_input_one_i(analog_input_one_i),
    .max_speed_i(max_speed_i), .phase_loss_i(phase_loss_i),
    .ground_fault_i(ground_fault_i), .pos_deviation_i(pos_deviation_i),
    .speed_deviation_i(speed_deviation_i), .homing_done_i(homing_done_i),
    .pos_actual_i(pos_actual_i),
    .soft_limit_positive_i(soft_limit_positive_i),
    .soft_limit_negative_i(soft_limit_negative_i),
    .speed_ref_o(speed_ref_o), .following_error_o(following_error_o),
    .fault_o(fault_o), .limit_pos_hit_o(limit_pos_hit_o),
    .limit_neg_hit_o(limit_neg_hit_o));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic signed [15:0] exp_spd(input logic mode,
    input logic [1:0] s, input logic signed [15:0] a, input int p,
    input logic [15:0] mx);
    if (!mode || s == 2'h0)
      return 16'sh0;
    if (s == 2'h1)
      return a;
    if (p > int'(mx))
      return mx;
    if (p < -int'(mx))
      return 16'(-int'(mx));
    return 16'(p);
  endfunction

  function automatic logic [1:0] exp_cls(input logic a, input logic b,
    input logic [1:0] ca, input logic [1:0] cb);
    logic [1:0] x, y;
    x = a ? ca : 2'h0;
    y = b ? cb : 2'h0;
    return (x > y) ? x : y;
  endfunction

  task automatic chk_rsp(input logic [31:0] gd, input logic ge,
    input logic [31:0] ed, input logic ee);
    check_count++;
    if (gd !== ed || ge !== ee)
    begin
      n_mismatch++;
      $display("wrong value at %0t: answer %h/%b expected %h/%b", $time,
        gd, ge, ed, ee);
    end
  endtask

  task automatic chk_sig(input logic [32:0] g, input logic [32:0] e,
    input string m);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] a,
    input logic [31:0] wd, input logic [31:0] ed, input logic ee);
    logic [31:0] d;
    logic e;
    u_mst.access(wr, a, wd, d, e);
    chk_rsp(d, e, ed, ee);
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    {reset_n_i, speed_mode_i, phase_loss_i, ground_fault_i} = '0;
    {homing_done_i, analog_input_one_i, max_speed_i} = '0;
    {pos_deviation_i, speed_deviation_i, pos_actual_i} = '0;
    {soft_limit_positive_i, soft_limit_negative_i} = '0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 8; i++)
      acc(1'b0, adr_t[i], 32'h0, rst_t[i], 1'b0);
    acc(1'b0, 16'h0600, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      acc(1'b1, adr_t[bad_i[i]], bad_d[i], 32'h0, 1'b1);
      acc(1'b0, adr_t[bad_i[i]], 32'h0, rst_t[bad_i[i]], 1'b0);
    end
    acc(1'b1, DSC_ADR_FELIM, 32'h1E8480, 32'h0, 1'b0);
    acc(1'b0, DSC_ADR_FELIM, 32'h0, 32'h1E8480, 1'b0);
    acc(1'b1, DSC_ADR_SPDSET, 32'hFFFF8AD0, 32'h0, 1'b0);
    acc(1'b0, DSC_ADR_SPDSET, 32'h0, 32'hFFFF8AD0, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      src = 2'(k % 3);
      sp = (k == 0) ? 30000 : int'(rnd() % 60001) - 30000;
      speed_mode_i = (k < 9);
      analog_input_one_i = 16'(rnd());
      max_speed_i = 16'(rnd() % 20000);
      acc(1'b1, DSC_ADR_SPDSRC, {30'h0, src}, 32'h0, 1'b0);
      acc(1'b1, DSC_ADR_SPDSET, 32'(sp), 32'h0, 1'b0);
      repeat (2) @(negedge clk_i);
      chk_sig(speed_ref_o, exp_spd(speed_mode_i, src, analog_input_one_i,
        sp, max_speed_i), "speed ref");
    end
    for (int k = 0; k < 16; k++)
    begin
      pc = 2'(1 + rnd() % 3);
      fc = 2'(1 + rnd() % 3);
      lim = 1 + int'(rnd() % 1000);
      acc(1'b1, DSC_ADR_PHASE, {30'h0, pc}, 32'h0, 1'b0);
      acc(1'b1, DSC_ADR_FOLLOW, {30'h0, fc}, 32'h0, 1'b0);
      acc(1'b1, DSC_ADR_FELIM, 32'(lim), 32'h0, 1'b0);
      acc(1'b1, DSC_ADR_LINE, {31'h0, k[0]}, 32'h0, 1'b0);
      // ground enable cleared on every pass with k[1] low, whatever the fault inputs
      acc(1'b1, DSC_ADR_GROUND, {31'h0, k[1]}, 32'h0, 1'b0);
      {ground_fault_i, phase_loss_i} = 2'(rnd());
      pos_deviation_i = int'(rnd() % 4000) - 2000;
      speed_deviation_i = int'(rnd() % 4000) - 2000;
      if (k == 3)
        speed_deviation_i = pos_deviation_i - lim;
      if (k == 4)
        speed_deviation_i = pos_deviation_i + lim + 1;
      dv = pos_deviation_i - speed_deviation_i;
      repeat (2) @(negedge clk_i);
      ph = phase_loss_i & k[0];
      fe = (dv > lim) || (-dv > lim);
      gr = ground_fault_i & k[1];
      exp_f = '{phase_loss: ph, follow_err: fe, ground: gr,
        cls: exp_cls(ph, fe, pc, fc)};
      chk_sig(following_error_o, 33'(dv), "follow error");
      chk_sig(fault_o, exp_f,
        "faults");
    end
    for (int k = 0; k < 16; k++)
    begin
      acc(1'b1, DSC_ADR_SOFTLIM, 32'(k % 4), 32'h0, 1'b0);
      homing_done_i = k[2];
      pos_actual_i = int'(rnd() % 100000) - 50000;
      soft_limit_positive_i = pos_actual_i - 32'(k[3]);
      soft_limit_negative_i = pos_actual_i + 32'(k[3]);
      repeat (2) @(negedge clk_i);
      chk_sig(limit_pos_hit_o, k[2] & k[0] & k[3], "pos hit");
      chk_sig(limit_neg_hit_o, k[2] & k[1] & k[3], "neg hit");
    end
    summarize();
  end

  initial
  begin
    repeat (4000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
endmodule
